//--- core/cscb_regs.vh
// register offsets, field positions and reset values of the control bank
`ifndef CSCB_REGS_VH
`define CSCB_REGS_VH
`define CSCB_ADDR_W        7
`define CSCB_OFS_CFG       7'h00
`define CSCB_OFS_PWD       7'h01
`define CSCB_OFS_CLK       7'h02
`define CSCB_OFS_IRQEN     7'h03
`define CSCB_OFS_STAT      7'h04
`define CSCB_CFG_WIRE3     7
`define CSCB_CFG_LSBF      6
`define CSCB_CFG_SWRST     5
`define CSCB_PWD_DRV       5
`define CSCB_PWD_RCV       4
`define CSCB_PWD_CLKR      1
`define CSCB_PWD_BIAS      0
`define CSCB_CLK_DIST      3
`define CSCB_CLK_RX        1
`define CSCB_CLK_PH        0
`define CSCB_EN_PH_LOSS    3
`define CSCB_EN_PH_LOCK    2
`define CSCB_EN_RX_LOSS    1
`define CSCB_EN_RX_LOCK    0
`define CSCB_CFG_RST       8'h00
`define CSCB_PWD_RST       8'h00
`define CSCB_CLK_RST       8'h03
`define CSCB_IRQEN_RST     8'h00
`define CSCB_STAT_RST      4'h0
`define CSCB_CFG_MASK      8'hE0
`define CSCB_PWD_MASK      8'h33
`define CSCB_CLK_MASK      8'h0B
`define CSCB_EN_MASK       8'h0F
`define CSCB_BITCNT_W      4
`define CSCB_HDR_BITS      4'h8
`define CSCB_XFER_BITS     4'hF
`define CSCB_BITCNT_ZERO   4'h0
`define CSCB_BITCNT_ONE    4'h1
`define CSCB_ZERO8         8'h00
`endif

//--- core/cscb_sync.v
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
module cscb_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk_sys_i,
  input  wire rst_b_i,
  input  wire pin_i,
  output reg  level_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // s1 is read only by s2; a change counts once s2 and s3 agree
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r    <= RST_VAL;
      s2_r    <= RST_VAL;
      s3_r    <= RST_VAL;
      level_o <= RST_VAL;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule

//--- core/cscb_bank.v
// control register bank with serial configuration port
`timescale 1ns/1ps
`include "cscb_regs.vh"
// How it works
// R01: config bit 7 picks four-wire (0) or three-wire shared data (1).
// R02: config bit 6 picks msb first (0) or lsb first (1).
// R03: software reset bit high resets all registers except config register.
// R04: software reset bit low releases reset, other registers accept writes.
// R05: register 1 bits 5,4,1,0 power down circuits; reset 0, 1 disables.
// R06: register 2 bit 3 disables clock distribution when 1, reset 0.
// R07: register 2 bits 1 and 0 gate receive and phase controller clocks.
// R08: controller clock gates reset to 1; 1 runs, 0 stops the clock.
// R09: register 3 holds four write-only status update enables, reset 0.
// R10: writing 0 to an enable blocks updates and clears its status bit.
// R11: status bits report per controller currently locked and lost lock.
// R12: host should soft reset before changing registers from defaults.
// R13: internal reset is power-on reset or reset pin or software reset.
// R14: host writes 0 to undefined bits and skips undefined addresses.
// R15: host clears then re-sets an enable after servicing an interrupt.
// R16: a write takes effect only when the last data bit arrives.
module cscb_bank (
  input  wire       clk_sys_i,
  input  wire       rst_b_i,
  input  wire       reset_pin_i,
  input  wire       sclk_i,
  input  wire       cs_b_i,
  input  wire       sdio_i,
  output reg        sdio_o,
  output reg        sdio_oe_o,
  output reg        sdo_o,
  output reg        sdo_oe_o,
  input  wire       phase_locked_i,
  input  wire       rx_locked_i,
  output reg        wire3_mode_o,
  output reg        lsb_first_o,
  output reg        diff_driver_powerdown_o,
  output reg        diff_receiver_powerdown_o,
  output reg        clock_receiver_powerdown_o,
  output reg        converter_bias_powerdown_o,
  output reg        clock_distribution_powerdown_o,
  output reg        rx_controller_clock_on_o,
  output reg        phase_controller_clock_on_o,
  output reg  [3:0] status_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_HDR  = 3'b010;
  localparam ST_DATA = 3'b100;

  wire       sclk_s;
  wire       cs_b_s;
  wire       sdio_s;
  wire       rstpin_s;
  reg        sclk_d_r;
  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [`CSCB_BITCNT_W-1:0] cnt_r;
  reg  [7:0] shift_r;
  reg        rd_r;
  reg  [`CSCB_ADDR_W-1:0] addr_r;
  reg  [7:0] tx_r;
  reg  [7:0] cfg_r;
  reg  [7:0] pwd_r;
  reg  [7:0] clk_r;
  reg  [7:0] en_r;
  reg  [3:0] stat_r;
  reg        por_done_r;
  wire       rise;
  wire       fall;
  wire [7:0] rx_byte;
  wire       int_rst;

  cscb_sync #(.RST_VAL(1'b0)) u_sclk (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .pin_i(sclk_i), .level_o(sclk_s));
  cscb_sync #(.RST_VAL(1'b1)) u_cs (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .pin_i(cs_b_i), .level_o(cs_b_s));
  cscb_sync #(.RST_VAL(1'b0)) u_sdio (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .pin_i(sdio_i), .level_o(sdio_s));
  cscb_sync #(.RST_VAL(1'b0)) u_rpin (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .pin_i(reset_pin_i), .level_o(rstpin_s));

  // bit order reverses both header and data bytes
  function [7:0] cscb_order;
    input [7:0] v;
    input       lsbf;
    integer i;
    begin
      cscb_order = v;
      if (lsbf) begin
        for (i = 0; i < 8; i = i + 1) begin
          cscb_order[i] = v[7-i];
        end
      end
    end
  endfunction

  assign rise    = sclk_s & ~sclk_d_r;
  assign fall    = ~sclk_s & sclk_d_r;
  assign rx_byte = cscb_order({shift_r[6:0], sdio_s}, cfg_r[`CSCB_CFG_LSBF]);
  // por pulse for one cycle after release, plus pin and soft reset
  assign int_rst = ~por_done_r | rstpin_s
                 | cfg_r[`CSCB_CFG_SWRST];              // see R13 see R03

  ////////////////////////////////////////////////////////////////////////
  // serial framing state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (!cs_b_s) state_nxt = ST_HDR;
      ST_HDR:  if (rise && cnt_r == `CSCB_HDR_BITS - `CSCB_BITCNT_ONE)
                 state_nxt = ST_DATA;
      ST_DATA: if (rise && cnt_r == `CSCB_XFER_BITS) state_nxt = ST_HDR;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // deselect mid-byte aborts; on a byte boundary it only stalls
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r  <= ST_IDLE;
      cnt_r    <= `CSCB_BITCNT_ZERO;
      shift_r  <= `CSCB_ZERO8;
      rd_r     <= 1'b0;
      addr_r   <= {`CSCB_ADDR_W{1'b0}};
      sclk_d_r <= 1'b0;
      por_done_r <= 1'b0;
    end else begin
      sclk_d_r   <= sclk_s;
      por_done_r <= 1'b1;
      if (cs_b_s && cnt_r[2:0] != 3'h0) begin
        state_r <= ST_IDLE;
        cnt_r   <= `CSCB_BITCNT_ZERO;
      end else if (!cs_b_s) begin
        state_r <= state_nxt;
        if (rise) begin
          shift_r <= {shift_r[6:0], sdio_s};
          cnt_r   <= cnt_r + `CSCB_BITCNT_ONE;
          if (state_r == ST_HDR &&
              cnt_r == `CSCB_HDR_BITS - `CSCB_BITCNT_ONE) begin
            rd_r   <= rx_byte[7];
            addr_r <= rx_byte[6:0];
          end
          if (cnt_r == `CSCB_XFER_BITS) begin
            cnt_r <= `CSCB_BITCNT_ZERO;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers; write lands on the last data bit edge
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_r  <= `CSCB_CFG_RST;
      pwd_r  <= `CSCB_PWD_RST;
      clk_r  <= `CSCB_CLK_RST;
      en_r   <= `CSCB_IRQEN_RST;
      stat_r <= `CSCB_STAT_RST;
    end else begin
      if (!cs_b_s && rise && state_r == ST_DATA &&
          cnt_r == `CSCB_XFER_BITS && !rd_r) begin      // see R16
        case (addr_r)
          `CSCB_OFS_CFG: cfg_r <= rx_byte & `CSCB_CFG_MASK; // see R01 see R02
          `CSCB_OFS_PWD: pwd_r <= rx_byte & `CSCB_PWD_MASK; // see R05 see R04
          `CSCB_OFS_CLK: clk_r <= rx_byte & `CSCB_CLK_MASK; // see R06 see R07
          `CSCB_OFS_IRQEN: en_r  <= rx_byte & `CSCB_EN_MASK;  // see R09
          default: ;
        endcase
      end
      // status follows controllers only while enabled; disable clears
      stat_r[`CSCB_EN_PH_LOSS] <= en_r[`CSCB_EN_PH_LOSS] & ~phase_locked_i;
      stat_r[`CSCB_EN_PH_LOCK] <= en_r[`CSCB_EN_PH_LOCK] & phase_locked_i;
      stat_r[`CSCB_EN_RX_LOSS] <= en_r[`CSCB_EN_RX_LOSS] & ~rx_locked_i;
      stat_r[`CSCB_EN_RX_LOCK] <= en_r[`CSCB_EN_RX_LOCK]
                                & rx_locked_i;           // see R10 see R11
      // soft reset wins over a write and spares the config register
      if (int_rst) begin                                 // see R03 see R13
        pwd_r  <= `CSCB_PWD_RST;
        clk_r  <= `CSCB_CLK_RST;                         // see R08
        en_r   <= `CSCB_IRQEN_RST;
        stat_r <= `CSCB_STAT_RST;
        if (!por_done_r || rstpin_s) cfg_r <= `CSCB_CFG_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data: loaded after header, shifted on falling edges
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_r      <= `CSCB_ZERO8;
      sdio_o    <= 1'b0;
      sdio_oe_o <= 1'b0;
      sdo_o     <= 1'b0;
      sdo_oe_o  <= 1'b0;
    end else begin
      if (!cs_b_s && rise && state_r == ST_HDR &&
          cnt_r == `CSCB_HDR_BITS - `CSCB_BITCNT_ONE) begin
        // enable register is write-only and reads as zero
        case (rx_byte[6:0])
          `CSCB_OFS_CFG:  tx_r <= cscb_order(cfg_r, cfg_r[`CSCB_CFG_LSBF]);
          `CSCB_OFS_PWD:  tx_r <= cscb_order(pwd_r, cfg_r[`CSCB_CFG_LSBF]);
          `CSCB_OFS_CLK:  tx_r <= cscb_order(clk_r, cfg_r[`CSCB_CFG_LSBF]);
          `CSCB_OFS_STAT: tx_r <= cscb_order({4'h0, stat_r},
                                             cfg_r[`CSCB_CFG_LSBF]);
          default:        tx_r <= `CSCB_ZERO8;
        endcase
      end else if (fall && state_r == ST_DATA) begin
        sdio_o <= tx_r[7];
        sdo_o  <= tx_r[7];
        tx_r   <= {tx_r[6:0], 1'b0};
      end
      sdio_oe_o <= !cs_b_s && state_r == ST_DATA && rd_r &&
                   cfg_r[`CSCB_CFG_WIRE3];               // see R01
      sdo_oe_o  <= !cs_b_s && state_r == ST_DATA && rd_r &&
                   !cfg_r[`CSCB_CFG_WIRE3];
    end
  end

  // outward control levels, each from a flip-flop
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wire3_mode_o                   <= 1'b0;
      lsb_first_o                    <= 1'b0;
      diff_driver_powerdown_o        <= 1'b0;
      diff_receiver_powerdown_o      <= 1'b0;
      clock_receiver_powerdown_o     <= 1'b0;
      converter_bias_powerdown_o     <= 1'b0;
      clock_distribution_powerdown_o <= 1'b0;
      rx_controller_clock_on_o       <= 1'b1;
      phase_controller_clock_on_o    <= 1'b1;
      status_o                       <= `CSCB_STAT_RST;
    end else begin
      wire3_mode_o                   <= cfg_r[`CSCB_CFG_WIRE3];
      lsb_first_o                    <= cfg_r[`CSCB_CFG_LSBF];  // see R02
      diff_driver_powerdown_o        <= pwd_r[`CSCB_PWD_DRV];   // see R05
      diff_receiver_powerdown_o      <= pwd_r[`CSCB_PWD_RCV];
      clock_receiver_powerdown_o     <= pwd_r[`CSCB_PWD_CLKR];
      converter_bias_powerdown_o     <= pwd_r[`CSCB_PWD_BIAS];
      clock_distribution_powerdown_o <= clk_r[`CSCB_CLK_DIST];  // see R06
      rx_controller_clock_on_o       <= clk_r[`CSCB_CLK_RX];    // see R07
      phase_controller_clock_on_o    <= clk_r[`CSCB_CLK_PH];    // see R08
      status_o                       <= stat_r;
    end
  end
endmodule

//--- dv/cscb_monitor.sv
// port checker for the control bank
`timescale 1ns/1ps
module cscb_monitor (
  input wire       clk_sys_i,
  input wire       rst_b_i,
  input wire       reset_pin_i,
  input wire       sclk_i,
  input wire       cs_b_i,
  input wire       sdio_oe_o,
  input wire       sdo_oe_o,
  input wire       phase_locked_i,
  input wire       rx_locked_i,
  input wire       wire3_mode_o,
  input wire       lsb_first_o,
  input wire       diff_driver_powerdown_o,
  input wire       clock_distribution_powerdown_o,
  input wire       rx_controller_clock_on_o,
  input wire       phase_controller_clock_on_o,
  input wire [3:0] status_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////
  // only the selected wire mode may drive a data pin
  a_sdo_quiet_three: assert property (wire3_mode_o |-> !sdo_oe_o)
    else $error("sdo driven in three-wire mode");
  a_sdio_quiet_four: assert property (!wire3_mode_o |-> !sdio_oe_o)
    else $error("sdio driven in four-wire mode");
  // resets never set the first three or clear the receive clock gate, so such an edge must come from a finished byte
  a_lsb_byte_end: assert property (
    $rose(lsb_first_o) |-> sclk_i && !cs_b_i)
    else $error("bit order changed outside byte end");
  a_drv_byte_end: assert property (
    $rose(diff_driver_powerdown_o) |-> sclk_i && !cs_b_i)
    else $error("driver power-down set outside byte end");
  a_dist_byte_end: assert property (
    $rose(clock_distribution_powerdown_o) |-> sclk_i && !cs_b_i)
    else $error("distribution gate set outside byte end");
  a_rxclk_byte_end: assert property (
    $fell(rx_controller_clock_on_o) |-> sclk_i && !cs_b_i)
    else $error("receive clock stopped outside byte end");
  // a set status flag needs the matching lock level two cycles before
  a_ph_lock_src: assert property (
    status_o[2] |-> $past(phase_locked_i, 2))
    else $error("phase lock flag without lock");
  a_ph_loss_src: assert property (
    status_o[3] |-> !$past(phase_locked_i, 2))
    else $error("phase loss flag while locked");
  a_rx_lock_src: assert property (
    status_o[0] |-> $past(rx_locked_i, 2))
    else $error("receive lock flag without lock");
  a_rx_loss_src: assert property (
    status_o[1] |-> !$past(rx_locked_i, 2))
    else $error("receive loss flag while locked");
  a_pin_reset: assert property (
    reset_pin_i [*7] |-> !wire3_mode_o && !lsb_first_o
    && !diff_driver_powerdown_o && rx_controller_clock_on_o
    && phase_controller_clock_on_o) else $error("reset pin did not reset");
  c_three_read: cover property (sdio_oe_o);
  c_ph_loss: cover property (status_o[3]);
  c_lsb_three: cover property (lsb_first_o && wire3_mode_o);
endmodule
bind cscb_bank cscb_monitor mon (.*);

//--- dv/cscb_host.sv
// serial host model for the configuration port
`timescale 1ns/1ps
module cscb_host (
  input  wire clk_sys_i,
  input  wire dev_sdio_i,
  input  wire dev_sdio_oe_i,
  input  wire dev_sdo_i,
  input  wire dev_sdo_oe_i,
  output reg  sclk_o,
  output reg  cs_b_o,
  output wire line_o
);
  localparam H = 12; // half period, slower than 20 MHz sclk
  reg drv_r  = 1'b0;
  reg dat_r  = 1'b0;
  reg last_r = 1'b0;
  initial sclk_o = 1'b0;
  initial cs_b_o = 1'b1;
  ////////////////////////////////////////
  // a released line toggles, so a stale value never reads as data
  assign line_o = dev_sdio_oe_i ? dev_sdio_i : drv_r ? dat_r : ~last_r;
  always @(posedge clk_sys_i) last_r <= line_o;
  // w is {rw, addr, data}; sclk idles low between frames
  task xfer(input [15:0] w, input lsbf, input w3, output [7:0] rd);
    integer i;
    begin
      rd = 8'h00;
      cs_b_o <= 1'b0;
      repeat (H) @(posedge clk_sys_i);
      for (i = 0; i < 16; i = i + 1) begin
        drv_r <= !(w[15] && w3 && i > 7);
        dat_r <= w[(i < 8 ? 8 : 0) + (lsbf ? i % 8 : 7 - i % 8)];
        sclk_o <= 1'b0;
        repeat (H) @(posedge clk_sys_i);
        sclk_o <= 1'b1;
        // an undriven output pin reads as unknown, so a missing enable fails
        if (i > 7 && (w3 ? dev_sdio_oe_i : dev_sdo_oe_i))
          rd[lsbf ? i - 8 : 15 - i] = w3 ? line_o : dev_sdo_i;
        else if (i > 7)
          rd[lsbf ? i - 8 : 15 - i] = 1'bx;
        repeat (H) @(posedge clk_sys_i);
      end
      sclk_o <= 1'b0;
      drv_r <= 1'b0;
      repeat (H) @(posedge clk_sys_i);
      cs_b_o <= 1'b1;
      repeat (H) @(posedge clk_sys_i);
    end
  endtask
endmodule

//--- dv/converter_spi_control_bank_test.sv
// self-checking bench for the control bank
`timescale 1ns/1ps
module converter_spi_control_bank_test;
  reg         clk_sys_i   = 1'b0;
  reg         rst_b_i     = 1'b0;
  reg         reset_pin_i = 1'b0;
  reg         ph_lock     = 1'b0;
  reg         rx_lock     = 1'b0;
  wire        sclk;
  wire        cs_b;
  wire        line;
  wire        sdio_o;
  wire        sdio_oe_o;
  wire        sdo_o;
  wire        sdo_oe_o;
  wire [12:0] obs;
  reg  [7:0]  m0, m1, m2, m3, v;
  integer     bad_count = 0;
  integer     checks    = 0;
  integer     i;
  ////////////////////////////////////////
  cscb_bank uut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .reset_pin_i(reset_pin_i), .sclk_i(sclk), .cs_b_i(cs_b),
    .sdio_i(line), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .phase_locked_i(ph_lock),
    .rx_locked_i(rx_lock), .wire3_mode_o(obs[12]),
    .lsb_first_o(obs[11]), .diff_driver_powerdown_o(obs[10]),
    .diff_receiver_powerdown_o(obs[9]),
    .clock_receiver_powerdown_o(obs[8]),
    .converter_bias_powerdown_o(obs[7]),
    .clock_distribution_powerdown_o(obs[6]),
    .rx_controller_clock_on_o(obs[5]),
    .phase_controller_clock_on_o(obs[4]), .status_o(obs[3:0]));
  cscb_host host (.clk_sys_i(clk_sys_i), .dev_sdio_i(sdio_o),
    .dev_sdio_oe_i(sdio_oe_o), .dev_sdo_i(sdo_o),
    .dev_sdo_oe_i(sdo_oe_o), .sclk_o(sclk),
    .cs_b_o(cs_b), .line_o(line));
  always #5 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////
  // expected outputs from the register shadows and lock levels
  function [12:0] f();
    f = {m0[7:6], m1[5:4], m1[1:0], m2[3], m2[1:0], m3[3] & !ph_lock,
         m3[2] & ph_lock, m3[1] & !rx_lock, m3[0] & rx_lock};
  endfunction
  task cmp_out(input [12:0] got, input [12:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cmp_rd(input [7:0] got, input [7:0] exp);
    cmp_out({5'h00, got}, {5'h00, exp});
  endtask
  task dflt(input all);
    begin
      if (all) m0 = 8'h00;
      m1 = 8'h00;
      m2 = 8'h03;
      m3 = 8'h00;
    end
  endtask
  // shadows follow each write; soft reset overrides 1..3
  task wr(input [6:0] a, input [7:0] d);
    begin
      host.xfer({1'b0, a, d}, m0[6], m0[7], v);
      if (a == 7'h00) m0 = d;
      if (a == 7'h01) m1 = d;
      if (a == 7'h02) m2 = d;
      if (a == 7'h03) m3 = d;
      if (m0[5]) dflt(1'b0);
    end
  endtask
  task rd(input [6:0] a);
    host.xfer({1'b1, a, 8'h00}, m0[6], m0[7], v);
  endtask
  task chk;
    begin
      cmp_out(obs, f());
      rd(7'h00);
      cmp_rd(v, m0);
      rd(7'h01);
      cmp_rd(v, m1);
      rd(7'h02);
      cmp_rd(v, m2);
    end
  endtask
  ////////////////////////////////////////
  task t_defaults;
    begin
      dflt(1'b1);
      chk;
      rd(7'h03);
      cmp_rd(v, 8'h00);
      rd(7'h05);
      cmp_rd(v, 8'h00);
      $display("defaults test done");
    end
  endtask
  task t_regs;
    reg [47:0] p;
    begin
      wr(7'h00, 8'h20);
      wr(7'h00, 8'h00);
      p = 48'h20100201_3300;
      for (i = 0; i < 6; i = i + 1) begin
        wr(7'h01, p[47 - 8 * i -: 8]);
        chk;
      end
      p = 48'h08000201_0B03;
      for (i = 0; i < 6; i = i + 1) begin
        wr(7'h02, p[47 - 8 * i -: 8]);
        chk;
      end
      $display("register test done");
    end
  endtask
  task t_soft;
    begin
      wr(7'h01, 8'h33);
      wr(7'h02, 8'h08);
      wr(7'h03, 8'h0F);
      wr(7'h00, 8'h20);
      chk;
      wr(7'h01, 8'h33);
      chk;
      wr(7'h00, 8'h00);
      wr(7'h01, 8'h11);
      chk;
      $display("soft reset test done");
    end
  endtask
  task t_order;
    begin
      wr(7'h00, 8'h40);
      wr(7'h01, 8'h31);
      chk;
      wr(7'h00, 8'hC0);
      wr(7'h02, 8'h0A);
      chk;
      wr(7'h00, 8'h80);
      chk;
      wr(7'h00, 8'h00);
      chk;
      $display("wire mode test done");
    end
  endtask
  task t_irq;
    begin
      ph_lock <= 1'b1;
      wr(7'h03, 8'h0F);
      cmp_out(obs, f());
      ph_lock <= 1'b0;
      rx_lock <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      cmp_out(obs, f());
      rd(7'h04);
      cmp_rd(v, {4'h0, m3[3] & !ph_lock, m3[2] & ph_lock,
                 m3[1] & !rx_lock, m3[0] & rx_lock});
      wr(7'h03, 8'h0A);
      cmp_out(obs, f());
      wr(7'h03, 8'h00);
      wr(7'h03, 8'h05);
      cmp_out(obs, f());
      $display("status test done");
    end
  endtask
  task t_pin;
    begin
      wr(7'h00, 8'h40);
      wr(7'h01, 8'h33);
      reset_pin_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      reset_pin_i <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      dflt(1'b1);
      chk;
      $display("reset pin test done");
    end
  endtask
  task summarize;
    begin
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // reset for two cycles, then every scenario in turn
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    t_defaults;
    t_regs;
    t_soft;
    t_order;
    t_irq;
    t_pin;
    summarize;
  end
endmodule
